// [common/fadc_pkg.sv]
// Package holding constants and types of the flash converter encoder block
package fadc_pkg;
	// ==========================================================
	// Sizes
	localparam int unsigned LEVEL_COUNT   = 127;	// Comparator levels
	localparam int unsigned RESULT_WIDTH  = 7;	// Result word width
	localparam int unsigned RESULT_MSB    = 6;	// Top result bit index
	localparam int unsigned COUNT_WIDTH   = 8;	// Width of the running count
	// ==========================================================
	// Timing in the time unit as printed, and cycles at the 20 MHz clock
	localparam int unsigned CLOCK_PERIOD_NS       = 50;
	localparam int unsigned STROBE_LOW_WIDTH_NS   = 22;	// Least low phase
	localparam int unsigned STROBE_HIGH_WIDTH_NS  = 18;	// Least high phase
	// Least times round up to whole cycles
	localparam int unsigned STROBE_LOW_CYCLES  =
		(STROBE_LOW_WIDTH_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
	localparam int unsigned STROBE_HIGH_CYCLES =
		(STROBE_HIGH_WIDTH_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
	// Result hold after strobe edge, and delay to new result, in cycles
	localparam int unsigned OUTPUT_HOLD_CYCLES  = 1;
	localparam int unsigned OUTPUT_DELAY_CYCLES = 3;
	// ==========================================================
	// Codes
	localparam logic [6:0] FULL_SCALE_POS = 7'h7f;
	localparam logic [6:0] FULL_SCALE_NEG = 7'h00;
	localparam logic [6:0] RESULT_RESET   = 7'h00;
	// ==========================================================
	// Types
	typedef logic [LEVEL_COUNT-1:0] fadc_thermo_t;	// One bit per comparator
	typedef logic [RESULT_WIDTH-1:0] fadc_word_t;

	// Coding controls travel together
	typedef struct packed {
		logic msb_invert_n;		// Low complements the top bit
		logic low_bits_invert_n;	// Low complements the six low bits
	} fadc_coding_s;
endpackage : fadc_pkg

// [src/fadc_buf2.sv]
// Two-entry valid/ready buffer for result words
`timescale 1ns/1ps
module fadc_buf2 (
	// Clock and reset
	input  wire logic              clk_i,
	input  wire logic              reset_i,
	// Fill side
	input  wire logic              in_valid_i,
	input  wire fadc_pkg::fadc_word_t in_data_i,
	output logic                   in_ready_o,
	// Drain side
	output logic                   out_valid_o,
	output fadc_pkg::fadc_word_t   out_data_o,
	input  wire logic              out_ready_i
);
	// ==========================================================
	// Storage
	fadc_pkg::fadc_word_t mem_reg [2];		// Two slots
	fadc_pkg::fadc_word_t mem_next [2];
	logic                 wr_reg, wr_next;		// Write slot
	logic                 rd_reg, rd_next;		// Read slot
	logic [1:0]           cnt_reg, cnt_next;	// Words held
	logic                 push, pop;

	// Next-state: push when room, pop when taken
	always_comb begin
		push     = in_valid_i && (cnt_reg != 2'h2);
		pop      = (cnt_reg != 2'h0) && out_ready_i;
		mem_next = mem_reg;
		wr_next  = wr_reg;
		rd_next  = rd_reg;
		if (push) begin
			mem_next[wr_reg] = in_data_i;
			wr_next          = ~wr_reg;
		end
		if (pop) begin
			rd_next = ~rd_reg;
		end
		cnt_next = cnt_reg + {1'b0, push} - {1'b0, pop};
	end

	// Registers
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			wr_reg  <= 1'b0;
			rd_reg  <= 1'b0;
			cnt_reg <= 2'h0;
		end else begin
			wr_reg  <= wr_next;
			rd_reg  <= rd_next;
			cnt_reg <= cnt_next;
		end
		mem_reg <= mem_next;
	end

	// Honest full and empty
	assign in_ready_o  = (cnt_reg != 2'h2);
	assign out_valid_o = (cnt_reg != 2'h0);
	assign out_data_o  = mem_reg[rd_reg];
endmodule : fadc_buf2

// [src/fadc_encoder.sv]
// Flash converter strobe capture, thermometer encoding and output coding
`timescale 1ns/1ps
module fadc_encoder (
	// Clock and reset
	input  wire logic                   clk_i,
	input  wire logic                   reset_i,
	// Comparator bank and strobe pin
	input  wire fadc_pkg::fadc_thermo_t comparator_i,	// Bit k on when input above level k
	input  wire logic                   sample_strobe_i,
	// Static coding controls
	input  wire fadc_pkg::fadc_coding_s coding_i,
	// Result stream
	output fadc_pkg::fadc_word_t        result_o,		// Bit 6 is result_bit_top
	output logic                        result_valid_o,
	input  wire logic                   result_ready_i,
	// Status
	output logic                        strobe_error_o	// Strobe phase too short, or word lost at a full buffer
);
	// ==========================================================
	// Input synchronisers
	logic [1:0] strobe_sync_reg, strobe_sync_next;
	fadc_pkg::fadc_thermo_t cmp_sync1_reg, cmp_sync2_reg;
	fadc_pkg::fadc_coding_s cod_sync1_reg, cod_sync2_reg;
	logic strobe_prev_reg;					// Edge detect, reads stage two only

	always_comb begin
		strobe_sync_next = {strobe_sync_reg[0], sample_strobe_i};
	end

	// Two flops on the strobe, comparator and coding pins before logic reads them
	always_ff @(posedge clk_i) begin
		strobe_sync_reg <= strobe_sync_next;
		cmp_sync1_reg   <= comparator_i;
		cmp_sync2_reg   <= cmp_sync1_reg;
		cod_sync1_reg   <= coding_i;
		cod_sync2_reg   <= cod_sync1_reg;
		strobe_prev_reg <= strobe_sync_reg[1];
	end

	logic strobe_rise;
	assign strobe_rise = strobe_sync_reg[1] && !strobe_prev_reg;

	// ==========================================================
	// Comparator latch: taken on the strobe edge
	fadc_pkg::fadc_thermo_t latch_reg, latch_next;

	always_comb begin
		latch_next = latch_reg;
		if (strobe_rise) begin
			latch_next = cmp_sync2_reg;
		end
	end

	// ==========================================================
	// Thermometer encoder: count of lit comparators
	// A count tolerates stray bubbles better than a priority search.
	logic [fadc_pkg::COUNT_WIDTH-1:0] ones;
	fadc_pkg::fadc_word_t             binary;
	fadc_pkg::fadc_word_t             coded;

	always_comb begin
		ones = '0;
		for (int k = 0; k < fadc_pkg::LEVEL_COUNT; k++) begin
			ones = ones + {7'h00, latch_reg[k]};
		end
		// All on gives positive full scale, none gives negative
		binary = ones[fadc_pkg::RESULT_WIDTH-1:0];
		coded  = binary;
		// Coding controls read steady, so no glitch guard needed
		if (!cod_sync2_reg.msb_invert_n) begin
			coded[fadc_pkg::RESULT_MSB] = ~binary[fadc_pkg::RESULT_MSB];
		end
		if (!cod_sync2_reg.low_bits_invert_n) begin
			coded[fadc_pkg::RESULT_MSB-1:0] = ~binary[fadc_pkg::RESULT_MSB-1:0];
		end
	end

	// ==========================================================
	// Conversion sequencer: hold old result, then present new
	typedef enum logic [1:0] {FADC_IDLE, FADC_HOLD, FADC_SHOW} fadc_state_e;
	fadc_state_e state_reg, state_next;
	logic [1:0]  delay_reg, delay_next;
	logic        push_valid;

	always_comb begin
		state_next = state_reg;
		delay_next = delay_reg;
		push_valid = 1'b0;
		unique case (state_reg)
			FADC_IDLE: begin
				if (strobe_rise) begin
					state_next = FADC_HOLD;
					delay_next = 2'h0;
				end
			end
			FADC_HOLD: begin
				// Old word stays on the pins for the hold time
				delay_next = delay_reg + 2'h1;
				if (delay_reg == 2'(fadc_pkg::OUTPUT_HOLD_CYCLES - 1)) begin
					state_next = FADC_SHOW;
				end
			end
			FADC_SHOW: begin
				// Encoder feeds the buffer straight, no staging flop
				push_valid = 1'b1;
				state_next = FADC_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			state_reg <= FADC_IDLE;
			delay_reg <= 2'h0;
			latch_reg <= '0;
		end else begin
			state_reg <= state_next;
			delay_reg <= delay_next;
			latch_reg <= latch_next;
		end
	end

	// ==========================================================
	// Two-entry buffer absorbs a receiver stall
	logic                 buf_in_ready, buf_out_valid;
	fadc_pkg::fadc_word_t buf_out_data;

	fadc_buf2 u_buf (
		.clk_i       (clk_i),
		.reset_i     (reset_i),
		.in_valid_i  (push_valid),
		.in_data_i   (coded),
		.in_ready_o  (buf_in_ready),
		.out_valid_o (buf_out_valid),
		.out_data_o  (buf_out_data),
		.out_ready_i (!result_valid_o || result_ready_i)
	);

	// ==========================================================
	// Output flops and strobe width checks
	fadc_pkg::fadc_word_t result_reg, result_next;
	logic valid_reg, valid_next, err_reg, err_next;
	logic [1:0] phase_reg, phase_next;			// Cycles in current strobe phase

	always_comb begin
		result_next = result_reg;
		valid_next  = valid_reg;
		err_next    = err_reg;
		phase_next  = (phase_reg == 2'h3) ? phase_reg : phase_reg + 2'h1;
		if (!valid_reg || result_ready_i) begin
			valid_next = buf_out_valid;
			if (buf_out_valid) begin
				result_next = buf_out_data;
			end
		end
		if (strobe_sync_reg[1] != strobe_prev_reg) begin
			phase_next = 2'h1;
			// Phase ending shorter than its least width, or lost word
			if (phase_reg < 2'(strobe_prev_reg ? fadc_pkg::STROBE_HIGH_CYCLES
			                                  : fadc_pkg::STROBE_LOW_CYCLES)) begin
				err_next = 1'b1;
			end
		end
		if (push_valid && !buf_in_ready) begin
			err_next = 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			result_reg <= fadc_pkg::RESULT_RESET;
			valid_reg  <= 1'b0;
			err_reg    <= 1'b0;
			phase_reg  <= 2'h3;
		end else begin
			result_reg <= result_next;
			valid_reg  <= valid_next;
			err_reg    <= err_next;
			phase_reg  <= phase_next;
		end
	end

	assign result_o       = result_reg;
	assign result_valid_o = valid_reg;
	assign strobe_error_o = err_reg;

	// ==========================================================
	// Checks
	// Strobe edge to word held in the buffer, in cycles
	localparam int DELAY_TO_BUF = fadc_pkg::OUTPUT_DELAY_CYCLES;
	a_hold_old_word: assert property (@(posedge clk_i) disable iff (reset_i)
		strobe_rise && result_valid_o && !result_ready_i |=> $stable(result_o))
		else $error("result changed while held");
	a_push_after_edge: assert property (@(posedge clk_i) disable iff (reset_i)
		strobe_rise && state_reg == FADC_IDLE |-> ##2 push_valid)
		else $error("conversion did not complete");
	a_word_buffered: assert property (@(posedge clk_i) disable iff (reset_i)
		strobe_rise && state_reg == FADC_IDLE |-> ##DELAY_TO_BUF buf_out_valid)
		else $error("word missing from buffer");
	a_latch_on_edge: assert property (@(posedge clk_i) disable iff (reset_i)
		strobe_rise |=> latch_reg == $past(cmp_sync2_reg))
		else $error("comparators not latched");
	a_full_scale_pos: assert property (@(posedge clk_i) disable iff (reset_i)
		(&latch_reg) && cod_sync2_reg == 2'b11 |-> coded == fadc_pkg::FULL_SCALE_POS)
		else $error("positive full scale wrong");
	a_full_scale_neg: assert property (@(posedge clk_i) disable iff (reset_i)
		(latch_reg == '0) && cod_sync2_reg == 2'b11 |-> coded == fadc_pkg::FULL_SCALE_NEG)
		else $error("negative full scale wrong");
	a_msb_invert: assert property (@(posedge clk_i) disable iff (reset_i)
		coded[6] == (binary[6] ^ !cod_sync2_reg.msb_invert_n))
		else $error("top bit coding wrong");
	a_low_invert: assert property (@(posedge clk_i) disable iff (reset_i)
		coded[5:0] == (binary[5:0] ^ {6{!cod_sync2_reg.low_bits_invert_n}}))
		else $error("low bits coding wrong");
	a_stall_keeps: assert property (@(posedge clk_i) disable iff (reset_i)
		result_valid_o && !result_ready_i |=> result_valid_o && $stable(result_o))
		else $error("stalled word lost");
	c_one_sample_strobe: cover property (@(posedge clk_i) disable iff (reset_i) push_valid);
	c_stall: cover property (@(posedge clk_i) disable iff (reset_i) !buf_in_ready);
	c_error: cover property (@(posedge clk_i) disable iff (reset_i) $rose(strobe_error_o));
endmodule : fadc_encoder

// [tb/fadc_capture_model.sv]
// Capture-side model: makes strobe pulses, drives the comparator bank, takes words
`timescale 1ns/1ps
module fadc_capture_model (
	// Clock
	input  wire logic               clk_i,
	// Strobe and comparator bank
	output fadc_pkg::fadc_thermo_t  comparator_o,
	output logic                    sample_strobe_o,
	// Result handshake
	output logic                    result_ready_o,
	input  wire logic               stall_i
);
	// ==========================================================
	// Ready has random gaps, so words queue up; stall holds it low
	initial begin
		comparator_o = '0;
		sample_strobe_o = 1'b0;
		result_ready_o = 1'b0;
	end
	always @(posedge clk_i) begin
		result_ready_o <= !stall_i && ($urandom_range(3) != 0);
	end
	// ==========================================================
	// One conversion; bank settles two cycles ahead of the strobe rise
	task automatic convert(input int level);
		comparator_o <= {127{1'b1}} >> (fadc_pkg::LEVEL_COUNT - level);
		repeat (2) @(posedge clk_i);
		sample_strobe_o <= 1'b1;
		repeat (2) @(posedge clk_i);
		sample_strobe_o <= 1'b0;
		repeat (4) @(posedge clk_i);
	endtask : convert
endmodule : fadc_capture_model

// [tb/test_flash_adc_encoder_output.sv]
// Self-checking bench for the flash converter encoder
`timescale 1ns/1ps
module test_flash_adc_encoder_output;
	logic                   clk_i;
	logic                   reset_i;
	logic                   stall;		// Receiver refuses all words
	fadc_pkg::fadc_thermo_t comp;
	logic                   strobe;
	fadc_pkg::fadc_coding_s coding;
	fadc_pkg::fadc_word_t   result;
	logic                   valid;
	logic                   ready;
	logic                   err;
	logic                   held;		// Word was offered but not taken
	fadc_pkg::fadc_word_t   held_word;
	logic                   strobe_q;
	logic                   valid_q;
	int                     lat;		// Cycles since strobe pin rose
	int                     errors;
	int                     n_compared;
	int                     cycles;
	logic [6:0]             q[$];		// Expected words in order
	int                     lv[6] = '{0, 1, 63, 64, 126, 127};

	fadc_encoder u_fadc_encoder (.clk_i(clk_i), .reset_i(reset_i), .comparator_i(comp),
		.sample_strobe_i(strobe), .coding_i(coding), .result_o(result),
		.result_valid_o(valid), .result_ready_i(ready), .strobe_error_o(err));
	fadc_capture_model u_fadc_capture_model (.clk_i(clk_i), .comparator_o(comp),
		.sample_strobe_o(strobe), .result_ready_o(ready), .stall_i(stall));

	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end
	// ==========================================================
	// Comparison and verdict
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic conclude();
		if (errors == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : conclude
	// Reference coding: count of bank bits on, then the two inversions
	function automatic logic [6:0] encode(input int level, input fadc_pkg::fadc_coding_s c);
		logic [6:0] w;
		w = level[6:0];
		if (!c.msb_invert_n) w[6] = ~w[6];
		if (!c.low_bits_invert_n) w[5:0] = ~w[5:0];
		return w;
	endfunction : encode
	task automatic drain();
		for (int i = 0; i < 200 && q.size() != 0; i++) @(posedge clk_i);
		check(8'(q.size()), 8'h0);
	endtask : drain
	// ==========================================================
	// Hang limit: an overrun counts as a mismatch and ends the run
	always @(posedge clk_i) begin
		cycles++;
		if (cycles > 20000) begin
			errors++;
			conclude();
		end
	end
	// Monitor: every taken word, word stability, latency
	always @(posedge clk_i) begin
		if (!reset_i && held) check(8'(result), 8'(held_word));
		if (!reset_i && valid && ready)
			check(8'(result), q.size() ? 8'(q.pop_front()) : 8'hff);
		if (!reset_i && valid && !valid_q) check(8'(lat >= 4 && lat <= 8), 8'h1);
		held <= valid && !ready && !reset_i;
		held_word <= result;
		valid_q <= valid;
		strobe_q <= strobe;
		lat <= (strobe && !strobe_q) ? 0 : lat + 1;
	end
	// ==========================================================
	// Main sequence
	initial begin
		void'($urandom(32'h5321));
		reset_i = 1'b1;
		stall = 1'b1;
		coding = 2'b11;
		repeat (8) @(posedge clk_i);
		check({result, valid}, 8'h0);
		check(8'(err), 8'h0);
		reset_i <= 1'b0;
		stall <= 1'b0;
		// Every coding, boundary and random levels
		for (int c = 0; c < 4; c++) begin
			coding <= fadc_pkg::fadc_coding_s'(c[1:0]);
			repeat (3) @(posedge clk_i);
			for (int k = 0; k < 10; k++) begin
				automatic int l = (k < 6) ? lv[k] : $urandom_range(127);
				q.push_back(encode(l, fadc_pkg::fadc_coding_s'(c[1:0])));
				u_fadc_capture_model.convert(l);
			end
			drain();
		end
		// Receiver stalls: three words kept, the fourth dropped and flagged
		stall <= 1'b1;
		repeat (2) @(posedge clk_i);
		for (int k = 0; k < 4; k++) begin
			check(8'(err), 8'h0);
			if (k < 3) q.push_back(encode(k + 20, coding));
			u_fadc_capture_model.convert(k + 20);
		end
		repeat (10) @(posedge clk_i);
		check(8'(err), 8'h1);
		stall <= 1'b0;
		drain();
		// Second reset clears outputs and the sticky flag
		reset_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		check({result, valid}, 8'h0);
		check(8'(err), 8'h0);
		reset_i <= 1'b0;
		q.push_back(encode(99, coding));
		u_fadc_capture_model.convert(99);
		drain();
		conclude();
	end
endmodule : test_flash_adc_encoder_output
